/* File: rtl/flash_id_pkg.sv */
// constants, types and pin bundles for the id, lock and power-state command block
// Function
// [R01] wake command ends when chip select rises; device returns to standby
// [R02] wake from deep power-down waits the wake delay; host keeps select high
// [R03] legacy signature command returns one byte, repeated while clocking continues
// [R04] host raises select only after the signature was read once
// [R05] wake and signature accepted in deep power-down, refused while busy
// [R06] id command: opcode, two dummy bytes, one address byte
// [R07] maker then part id shifted out msb first on falling clock
// [R08] address one swaps the order: part id first
// [R09] ids alternate while clocking; command ends when select rises
// [R10] enter command selects the one-time-programmable area for read and program
// [R11] status and lock register writes refused while in the secure area
// [R12] locked secure area accepts only reads and never changes
// [R13] secure-area mode blocks main array access
// [R14] leave command returns to main array addressing
// [R15] lock register read works any time and repeats while clocking; code refuses it in deep power-down and before the supply-valid delay
// [R16] bit 0 shows factory lock
// [R17] bit 4 shows continuous program mode, zero after reset
// [R18] bit 1 customer lock set by lock write, never cleared
// [R19] lock write needs no prior write enable
// [R20] lock write only executes when select rises on a byte boundary
// [R21] power-up enters standby with write enable latch cleared
// [R22] reset holds the logic and ignores every command
// [R23] reads wait supply-valid delay, writes wait write-unlock delay
// [R24] deep power-down ignores all but wake and signature commands
// [R25] lock register read opcode 2b, accepted during continuous program
// [R26] opcodes per command set, msb first, sampled on rising clock
package flash_id_pkg;
	// ************************************************************
	// opcodes
	// ************************************************************
	localparam logic [7:0] OP_WAKE  = 8'hab;
	localparam logic [7:0] OP_SLEEP = 8'hb9;
	localparam logic [7:0] OP_ID1   = 8'h90;
	localparam logic [7:0] OP_ID2   = 8'hef;
	localparam logic [7:0] OP_ID4   = 8'hdf;
	localparam logic [7:0] OP_ENTER = 8'hb1;
	localparam logic [7:0] OP_LEAVE = 8'hc1;
	localparam logic [7:0] OP_LOCKR = 8'h2b;
	localparam logic [7:0] OP_LOCKW = 8'h2f;
	localparam logic [7:0] OP_WR_EN = 8'h06;
	localparam logic [7:0] OP_WRDI  = 8'h04;
	localparam logic [7:0] ID_SWAP_ADDR = 8'h01;
	// ************************************************************
	// lock register fields and id values (id values arbitrary)
	// ************************************************************
	localparam int FACTORY_BIT = 0;
	localparam int CUSTOMER_BIT = 1;
	localparam int CPROG_BIT = 4;
	localparam logic [7:0] MAKER_ID = 8'h9d;
	localparam logic [7:0] PART_ID  = 8'h3c;
	localparam logic [7:0] SIGNATURE = 8'h3c;
	// ************************************************************
	// timing
	// ************************************************************
	localparam int CLK_MHZ = 125;
	localparam int SUPPLY_VALID_US = 100;
	localparam int WRITE_UNLOCK_US = 1000;
	localparam int WAKE_US = 10;
	localparam int SUPPLY_VALID_CYC = SUPPLY_VALID_US * CLK_MHZ;
	localparam int WRITE_UNLOCK_CYC = WRITE_UNLOCK_US * CLK_MHZ;
	localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
	// ************************************************************
	// types
	// ************************************************************
	typedef enum logic [7:0] {
		PH_IDLE = 8'h01,
		PH_CMD  = 8'h02,
		PH_ADDR = 8'h04,
		PH_SIG  = 8'h08,
		PH_ID   = 8'h10,
		PH_LOCK = 8'h20,
		PH_SINK = 8'h40,
		PH_TAIL = 8'h80
	} phase_t;
	typedef struct packed {
		logic       cs_n;
		logic       sclk;
		logic [3:0] sio;
	} spi_in_t;
	typedef struct packed {
		logic [3:0] sio;
		logic [3:0] oe;
	} spi_out_t;
endpackage : flash_id_pkg

/* File: rtl/sync2.sv */
// two flip-flop synchroniser for pin inputs
module sync2 #(
	parameter int WIDTH = 1
) (
	// clock and reset
	input  wire logic             core_clk,
	input  wire logic             arst_n,
	// data
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta <= '0;
			q    <= '0;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : sync2

/* File: rtl/delay_timer.sv */
// reloadable down counter, done while it stands at zero
module delay_timer #(
	parameter int COUNT = 4,
	parameter bit RUN_AT_RESET = 1'b0
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic arst_n,
	// control
	input  wire logic start,
	output logic      done
);
	localparam int W = $clog2(COUNT + 1);
	localparam logic [W-1:0] LOAD = W'(COUNT);
	localparam logic [W-1:0] INIT = RUN_AT_RESET ? LOAD : '0;
	logic [W-1:0] cnt;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= INIT;
		end else if (start) begin
			cnt <= LOAD;
		end else if (cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end
	assign done = (cnt == '0);
endmodule : delay_timer

/* File: rtl/flash_id_ctrl.sv */
// command interpreter for wake, signature, id read, secure area and lock register
module flash_id_ctrl #(
	parameter int SUPPLY_VALID_CYC = flash_id_pkg::SUPPLY_VALID_CYC,
	parameter int WRITE_UNLOCK_CYC = flash_id_pkg::WRITE_UNLOCK_CYC
) (
	// clock and power-on reset
	input  wire logic                  core_clk,
	input  wire logic                  arst_n,
	// serial pins
	input  wire flash_id_pkg::spi_in_t spi_i,
	output flash_id_pkg::spi_out_t     spi_o,
	// rest of device
	input  wire logic                  busy,
	input  wire logic                  cp_active,
	input  wire logic                  factory_lock,
	input  wire logic                  lock_nv,
	// state to rest of device
	output logic                       deep_pd,
	output logic                       otp_select,
	output logic                       write_enable_latch,
	output logic                       customer_lock,
	output logic                       lock_set_req,
	output logic                       main_array_allow,
	output logic                       otp_program_allow,
	output logic                       status_write_allow
);
	import flash_id_pkg::*;

	// ************************************************************
	// state
	// ************************************************************
	typedef struct packed {
		phase_t     phase;
		logic       sclk_q;
		logic       cs_q;
		logic [3:0] bitcnt;
		logic [1:0] bytecnt;
		logic [7:0] shin;
		logic [7:0] op;
		logic [7:0] shout;
		logic [3:0] ocnt;
		logic [2:0] lanes;
		logic       id_swap;
		logic       id_sel;
		logic       deep_pd;
		logic       waking;
		logic       wake_start;
		logic       secure;
		logic       we_latch;
		logic       cust_lock;
		logic       lock_loaded;
		logic       lock_set;
		logic       main_ok;
		logic       otp_ok;
		logic       sr_ok;
		spi_out_t   pins;
	} st_t;

	localparam st_t ST_RESET = '{
		phase: PH_IDLE, sclk_q: 1'b0, cs_q: 1'b0, lanes: 3'h1, default: '0
	};

	st_t        st;
	st_t        next_st;
	spi_in_t    pin;
	logic       read_ok;
	logic       write_ok;
	logic       wake_done;
	logic [7:0] lock_val;

	// ************************************************************
	// pin sampling and timers
	// ************************************************************
	sync2 #(.WIDTH(6)) u_sync (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.d        (spi_i),
		.q        (pin)
	);

	delay_timer #(.COUNT(SUPPLY_VALID_CYC), .RUN_AT_RESET(1'b1)) u_read_gate (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.start    (1'b0),
		.done     (read_ok)
	);

	delay_timer #(.COUNT(WRITE_UNLOCK_CYC), .RUN_AT_RESET(1'b1)) u_write_gate (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.start    (1'b0),
		.done     (write_ok)
	);

	delay_timer #(.COUNT(WAKE_CYC), .RUN_AT_RESET(1'b0)) u_wake (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.start    (st.wake_start),
		.done     (wake_done)
	);

	always_comb begin
		lock_val = 8'h00;
		lock_val[FACTORY_BIT] = factory_lock; // [R16]
		lock_val[CUSTOMER_BIT] = st.cust_lock; // [R18]
		lock_val[CPROG_BIT] = cp_active; // [R17]
	end

	// ************************************************************
	// command sequencing
	// ************************************************************
	logic       sck_rise;
	logic       sck_fall;
	logic       asleep;
	logic       rd_gate;
	logic       wr_gate;
	logic [3:0] nb;
	logic [7:0] sh;
	logic [7:0] ob;
	logic [3:0] obase;

	always_comb begin
		next_st = st;
		next_st.lock_set = 1'b0;
		next_st.wake_start = 1'b0;
		next_st.sclk_q = pin.sclk;
		next_st.cs_q = pin.cs_n;
		sck_rise = pin.sclk && !st.sclk_q;
		sck_fall = !pin.sclk && st.sclk_q;
		asleep = st.deep_pd || st.waking;
		rd_gate = read_ok && !asleep && !cp_active; // [R23] [R24]
		wr_gate = write_ok && !asleep && !busy && !cp_active; // [R23] [R24]
		nb = st.bitcnt + {1'b0, st.lanes};
		unique case (st.lanes)
			3'h2: sh = {st.shin[5:0], pin.sio[1:0]};
			3'h4: sh = {st.shin[3:0], pin.sio};
			default: sh = {st.shin[6:0], pin.sio[0]}; // [R26]
		endcase
		ob = 8'h00;
		obase = (st.ocnt == 4'h0) ? 4'h8 : st.ocnt;
		if (!st.lock_loaded) begin
			next_st.cust_lock = lock_nv;
			next_st.lock_loaded = 1'b1;
		end
		if (st.waking && wake_done && !st.wake_start) begin
			next_st.deep_pd = 1'b0; // [R02]
			next_st.waking = 1'b0;
		end
		if (pin.cs_n) begin
			if (!st.cs_q && st.bitcnt == 4'h0 &&
					(st.phase == PH_TAIL || st.phase == PH_SIG)) begin // [R04]
				case (st.op)
					OP_WAKE: begin
						if (st.deep_pd && !st.waking) begin
							next_st.waking = 1'b1; // [R01] [R02]
							next_st.wake_start = 1'b1;
						end
					end
					OP_SLEEP: next_st.deep_pd = 1'b1;
					OP_WR_EN: next_st.we_latch = 1'b1;
					OP_WRDI: next_st.we_latch = 1'b0;
					OP_ENTER: next_st.secure = 1'b1; // [R10]
					OP_LEAVE: next_st.secure = 1'b0; // [R14]
					OP_LOCKW: begin
						if (!st.cust_lock) begin
							next_st.cust_lock = 1'b1; // [R18] [R19] [R20]
							next_st.lock_set = 1'b1;
						end
					end
					default: next_st.op = st.op;
				endcase
			end
			next_st.phase = PH_IDLE; // [R09]
			next_st.bitcnt = 4'h0;
			next_st.ocnt = 4'h0;
			next_st.pins.oe = 4'h0;
		end else if (st.cs_q) begin
			next_st.phase = PH_CMD;
			next_st.bitcnt = 4'h0;
			next_st.bytecnt = 2'h0;
			next_st.lanes = 3'h1;
			next_st.id_sel = 1'b0;
			next_st.ocnt = 4'h0;
		end else if (sck_rise) begin
			next_st.shin = sh;
			next_st.bitcnt = nb[3] ? 4'h0 : nb;
			if (nb[3]) begin
				unique case (st.phase)
					PH_CMD: begin
						next_st.op = sh;
						next_st.phase = PH_SINK;
						case (sh)
							OP_WAKE: begin
								if (read_ok && !busy && !cp_active) begin
									next_st.phase = PH_SIG; // [R03] [R05]
								end
							end
							OP_ID1, OP_ID2, OP_ID4: begin
								if (rd_gate && !busy) begin
									next_st.phase = PH_ADDR; // [R06]
									next_st.lanes = (sh == OP_ID4) ? 3'h4 :
										(sh == OP_ID2) ? 3'h2 : 3'h1;
								end
							end
							OP_LOCKR: begin
								if (read_ok && !asleep) begin
									next_st.phase = PH_LOCK; // [R15] [R25]
								end
							end
							OP_LOCKW: begin
								if (wr_gate && !st.secure) begin
									next_st.phase = PH_TAIL; // [R11] [R12]
								end
							end
							OP_WR_EN, OP_WRDI: begin
								if (wr_gate) begin
									next_st.phase = PH_TAIL;
								end
							end
							OP_SLEEP, OP_ENTER, OP_LEAVE: begin
								if (rd_gate && !busy) begin
									next_st.phase = PH_TAIL;
								end
							end
							default: next_st.phase = PH_SINK;
						endcase
					end
					PH_ADDR: begin
						next_st.bytecnt = st.bytecnt + 2'h1;
						if (st.bytecnt == 2'h2) begin
							next_st.id_swap = (sh == ID_SWAP_ADDR); // [R08]
							next_st.phase = PH_ID;
						end
					end
					PH_IDLE, PH_SIG, PH_ID, PH_LOCK, PH_SINK, PH_TAIL: begin
						next_st.phase = st.phase;
					end
				endcase
			end
		end else if (sck_fall &&
				(st.phase == PH_SIG || st.phase == PH_ID || st.phase == PH_LOCK)) begin
			if (st.ocnt != 4'h0) begin
				ob = st.shout;
			end else if (st.phase == PH_SIG) begin
				ob = SIGNATURE; // [R03]
			end else if (st.phase == PH_LOCK) begin
				ob = lock_val; // [R15]
			end else begin
				ob = (st.id_sel ^ st.id_swap) ? PART_ID : MAKER_ID; // [R07] [R08]
				next_st.id_sel = !st.id_sel; // [R09]
			end
			next_st.shout = ob << st.lanes;
			next_st.ocnt = obase - {1'b0, st.lanes};
			unique case (st.lanes)
				3'h2: begin
					next_st.pins.sio = {2'b00, ob[7:6]};
					next_st.pins.oe = 4'h3;
				end
				3'h4: begin
					next_st.pins.sio = ob[7:4];
					next_st.pins.oe = 4'hf;
				end
				default: begin
					next_st.pins.sio = {2'b00, ob[7], 1'b0}; // [R07]
					next_st.pins.oe = 4'h2;
				end
			endcase
		end
		next_st.main_ok = !next_st.secure && !next_st.deep_pd; // [R13]
		next_st.otp_ok = next_st.secure && !next_st.cust_lock && !factory_lock &&
			write_ok; // [R12]
		next_st.sr_ok = !next_st.secure && write_ok; // [R11]
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st <= ST_RESET; // [R21] [R22]
		end else begin
			st <= next_st;
		end
	end

	// ************************************************************
	// outputs
	// ************************************************************
	assign spi_o = st.pins;
	assign deep_pd = st.deep_pd;
	assign otp_select = st.secure;
	assign write_enable_latch = st.we_latch;
	assign customer_lock = st.cust_lock;
	assign lock_set_req = st.lock_set;
	assign main_array_allow = st.main_ok;
	assign otp_program_allow = st.otp_ok;
	assign status_write_allow = st.sr_ok;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);

	sequence s_cs_rise;
		pin.cs_n && !st.cs_q;
	endsequence

	sequence s_wake_end;
		st.waking && wake_done && !st.wake_start;
	endsequence

	sequence s_lock_pulse;
		st.lock_set;
	endsequence

	a_wake_clear: assert property (s_wake_end |=> !st.deep_pd && !st.waking) // [R02]
		else $error("deep power-down not left after wake delay");
	a_cs_idle: assert property (s_cs_rise |=> st.phase == PH_IDLE && st.pins.oe == 4'h0) // [R09]
		else $error("command not ended on select rise");
	a_id_order: assert property ( // [R07]
		(!pin.cs_n && !st.cs_q && sck_fall && st.phase == PH_ID && st.ocnt == 4'h0 &&
			st.lanes == 3'h1)
		|=> st.pins.sio[1] == (($past(st.id_sel) ^ $past(st.id_swap)) ?
			PART_ID[7] : MAKER_ID[7]))
		else $error("wrong id byte order");
	a_lock_sticky: assert property (st.cust_lock && st.lock_loaded |=> st.cust_lock) // [R18]
		else $error("customer lock cleared");
	a_secure_block: assert property (st.secure |-> !st.main_ok) // [R13]
		else $error("main array allowed in secure mode");
	a_lockw_boundary: assert property ( // [R20]
		st.lock_set |-> $past(st.bitcnt) == 4'h0 && $past(st.op) == OP_LOCKW &&
			!$past(st.secure))
		else $error("lock write executed off boundary or in secure mode");
	a_dp_gate: assert property ((st.phase == PH_ID || st.phase == PH_TAIL) |-> !asleep) // [R24]
		else $error("command accepted in deep power-down");
	a_latch_unlock: assert property ($rose(st.we_latch) |-> write_ok) // [R23]
		else $error("write enable before unlock delay");
	a_set_pulse: assert property (s_lock_pulse |=> !st.lock_set) // [R18]
		else $error("customer lock programmed twice");
	a_sr_block: assert property (st.secure |-> !st.sr_ok) // [R11]
		else $error("status write allowed in secure mode");
	a_early_ignore: assert property ( // [R23]
		!read_ok |-> st.phase inside {PH_IDLE, PH_CMD, PH_SINK})
		else $error("command accepted before supply valid delay");
endmodule : flash_id_ctrl

/* File: tb/spi_host.sv */
// host serial master model: select, serial clock and four data lanes
module spi_host (
	// core clock, frames start on its falling edge
	input  wire logic       core_clk,
	// serial pins
	output logic            cs_n,
	output logic            sclk,
	output logic      [3:0] sio_drv,
	input  wire logic [3:0] sio_wire,
	// bytes read back
	output logic      [7:0] rx_byte,
	output logic            rx_stb
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sio_drv = 4'h0;
		rx_byte = 8'h00;
		rx_stb = 1'b0;
	end

	// one clock period, idle low, sample on rise
	task automatic pulse(input int ln);
		#62.5 sclk = 1'b1;
		if (ln == 1)
			rx_byte = {rx_byte[6:0], sio_wire[1]};
		if (ln == 2)
			rx_byte = {rx_byte[5:0], sio_wire[1:0]};
		if (ln == 4)
			rx_byte = {rx_byte[3:0], sio_wire};
		#62.5 sclk = 1'b0;
	endtask : pulse

	// byte out msb first, unused lanes toggle
	task automatic send(input logic [7:0] b, input int ln);
		logic [3:0] v;
		for (int i = 8 - ln; i >= 0; i -= ln) begin
			v = ~sio_drv;
			for (int k = 0; k < ln; k++)
				v[k] = b[i + k];
			sio_drv = v;
			pulse(0);
		end
	endtask : send

	// opcode, preamble bytes, stray bits, read bytes, then deselect
	task automatic frame(input logic [7:0] op, input int ln, input logic [23:0] pre,
		input int npre, input int xbits, input int nrd);
		@(negedge core_clk);
		cs_n = 1'b0;
		send(op, 1);
		for (int j = npre - 1; j >= 0; j--)
			send(pre[8*j +: 8], ln);
		for (int j = 0; j < xbits; j++) begin
			sio_drv = ~sio_drv;
			pulse(0);
		end
		for (int j = 0; j < nrd; j++) begin
			for (int k = 0; k < 8; k += ln) begin
				sio_drv = ~sio_drv;
				pulse(ln);
			end
			rx_stb = 1'b1;
			#4 rx_stb = 1'b0;
		end
		#62.5 cs_n = 1'b1;
		sio_drv = ~sio_drv;
		#500;
		@(negedge core_clk);
	endtask : frame
endmodule : spi_host

/* File: tb/testbench.sv */
// self-checking bench for the id, lock and power-state command block
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import flash_id_pkg::*;
	localparam int SV_CYC = 20;
	localparam int WU_CYC = 40;
	localparam int LIMIT  = 40000;

	logic        core_clk;
	logic        arst_n;
	spi_in_t     spi_i;
	spi_out_t    spi_o;
	logic        busy;
	logic        cp_active;
	logic        factory_lock;
	logic        deep_pd;
	logic        otp_select;
	logic        write_enable_latch;
	logic        lock_set_req;
	logic        lock_nv;
	logic        customer_lock;
	logic        main_array_allow;
	logic        otp_program_allow;
	logic        status_write_allow;
	logic        cs_n;
	logic        sclk;
	logic [3:0]  sio_drv;
	logic [3:0]  sio_wire;
	logic [7:0]  rx_byte;
	logic        rx_stb;
	logic        snap_stb;
	logic        unl;
	logic [7:0]  a;
	logic [15:0] rnd;
	logic [7:0]  exp_q[$];
	logic [7:0]  ops [3] = '{OP_ID1, OP_ID2, OP_ID4};
	int          lanes [3] = '{1, 2, 4};
	int          errors;
	int          num_checks;
	int          cyc;
	int          seed;

	// ************************************************************
	// design, host and wire resolution
	// ************************************************************
	assign sio_wire = (spi_o.oe & spi_o.sio) | (~spi_o.oe & sio_drv);
	assign spi_i = {cs_n, sclk, sio_wire};

	flash_id_ctrl #(.SUPPLY_VALID_CYC(SV_CYC), .WRITE_UNLOCK_CYC(WU_CYC)) DUT (
		.core_clk(core_clk), .arst_n(arst_n), .spi_i(spi_i), .spi_o(spi_o),
		.busy(busy), .cp_active(cp_active), .factory_lock(factory_lock),
		.lock_nv(lock_nv), .deep_pd(deep_pd), .otp_select(otp_select),
		.write_enable_latch(write_enable_latch), .customer_lock(customer_lock),
		.lock_set_req(lock_set_req),
		.main_array_allow(main_array_allow), .otp_program_allow(otp_program_allow),
		.status_write_allow(status_write_allow));

	spi_host host (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .sio_drv(sio_drv),
		.sio_wire(sio_wire), .rx_byte(rx_byte), .rx_stb(rx_stb));

	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;

	// ************************************************************
	// notes, comparison and verdict
	// ************************************************************
	task automatic note(input logic [7:0] e);
		exp_q.push_back(e);
	endtask : note

	task automatic cmp(input logic [7:0] got);
		logic [7:0] e;
		e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
		num_checks++;
		if (got !== e) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, e);
		end
	endtask : cmp

	// bits of s: deep, secure, wel, customer lock
	task automatic chk(input logic [3:0] s);
		note({s, !s[2] && !s[3], s[2] && !s[0] && !factory_lock && unl, !s[2] && unl, 1'b0});
		@(negedge core_clk);
		snap_stb = 1'b1;
		@(negedge core_clk);
		snap_stb = 1'b0;
	endtask : chk

	function automatic logic [7:0] lockv(input logic cl);
		return {3'h0, cp_active, 2'h0, cl, factory_lock};
	endfunction : lockv

	task automatic report_and_stop();
		if (errors == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : report_and_stop

	always @(posedge rx_stb) cmp(rx_byte);
	always @(posedge snap_stb) cmp({deep_pd, otp_select, write_enable_latch, customer_lock,
		main_array_allow, otp_program_allow, status_write_allow, |spi_o.oe});
	always @(negedge core_clk) if (lock_set_req === 1'b1) cmp(8'h01);

	always @(posedge core_clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			errors++;
			report_and_stop();
		end
	end

	// ************************************************************
	// main sequence
	// ************************************************************
	initial begin
		seed = 26117;
		arst_n = 1'b0;
		busy = 1'b0;
		cp_active = 1'b0;
		factory_lock = 1'b0;
		snap_stb = 1'b0;
		unl = 1'b0;
		lock_nv = 1'b0;
		errors = 0;
		num_checks = 0;
		cyc = 0;
		repeat (8) @(negedge core_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(4'h0);
		repeat (WU_CYC) @(negedge core_clk);
		unl = 1'b1;
		chk(4'h0);
		factory_lock = 1'($random(seed));
		note(lockv(1'b0));
		note(lockv(1'b0));
		host.frame(OP_LOCKR, 1, 24'h0, 0, 0, 2);
		cp_active = 1'b1;
		note(lockv(1'b0));
		host.frame(OP_LOCKR, 1, 24'h0, 0, 0, 1);
		host.frame(OP_WR_EN, 1, 24'h0, 0, 0, 0);
		chk(4'h0);
		cp_active = 1'b0;
		host.frame(OP_WR_EN, 1, 24'h0, 0, 0, 0);
		chk(4'h2);
		host.frame(OP_WRDI, 1, 24'h0, 0, 0, 0);
		chk(4'h0);
		for (int i = 0; i < 6; i++) begin
			rnd = 16'($random(seed));
			a = (i % 2) ? ID_SWAP_ADDR : 8'h00;
			note((i % 2) ? PART_ID : MAKER_ID);
			note((i % 2) ? MAKER_ID : PART_ID);
			note((i % 2) ? PART_ID : MAKER_ID);
			host.frame(ops[i / 2], lanes[i / 2], {rnd, a}, 3, 0, 3);
		end
		note(SIGNATURE);
		note(SIGNATURE);
		host.frame(OP_WAKE, 1, 24'h0, 0, 0, 2);
		busy = 1'b1;
		note(lockv(1'b0));
		host.frame(OP_LOCKR, 1, 24'h0, 0, 0, 1);
		host.frame(OP_SLEEP, 1, 24'h0, 0, 0, 0);
		chk(4'h0);
		busy = 1'b0;
		host.frame(OP_SLEEP, 1, 24'h0, 0, 0, 0);
		chk(4'h8);
		host.frame(OP_WR_EN, 1, 24'h0, 0, 0, 0);
		chk(4'h8);
		host.frame(OP_WAKE, 1, 24'h0, 0, 0, 0);
		chk(4'h8);
		repeat (WAKE_CYC + 40) @(negedge core_clk);
		chk(4'h0);
		host.frame(OP_ENTER, 1, 24'h0, 0, 0, 0);
		chk(4'h4);
		host.frame(OP_LOCKW, 1, 24'h0, 0, 0, 0);
		chk(4'h4);
		host.frame(OP_LEAVE, 1, 24'h0, 0, 0, 0);
		chk(4'h0);
		host.frame(OP_LOCKW, 1, 24'h0, 0, 1, 0);
		chk(4'h0);
		note(8'h01);
		host.frame(OP_LOCKW, 1, 24'h0, 0, 0, 0);
		chk(4'h1);
		note(lockv(1'b1));
		host.frame(OP_LOCKR, 1, 24'h0, 0, 0, 1);
		host.frame(OP_ENTER, 1, 24'h0, 0, 0, 0);
		chk(4'h5);
		host.frame(OP_LEAVE, 1, 24'h0, 0, 0, 0);
		host.frame(OP_LOCKW, 1, 24'h0, 0, 0, 0);
		chk(4'h1);
		host.frame(OP_WR_EN, 1, 24'h0, 0, 0, 0);
		chk(4'h3);
		arst_n = 1'b0;
		unl = 1'b0;
		lock_nv = 1'b1;
		repeat (8) @(negedge core_clk);
		arst_n = 1'b1;
		repeat (3) @(negedge core_clk);
		chk(4'h1);
		if (exp_q.size() != 0) begin
			errors++;
			$display("unexpected at %0t: results missing", $time);
		end
		report_and_stop();
	end
endmodule : testbench
